// >>> design/dlc_lock_detector.sv
// Leaky-bucket lock detector with hysteresis
`timescale 1ns/1ps
module dlc_lock_detector (
  input wire logic clk_sys,
  input wire logic rst,
  dlc_det_if.det   d
);
  logic signed [dlc_pkg::LVL_W+1:0] sum;
  logic signed [dlc_pkg::LVL_W-1:0] level_r;
  logic                             locked_r;
  logic                             fill;

  assign fill = (d.errMag <= d.threshold);

  // One step per sample, widened so saturation is checked before truncation
  always_comb begin
    if (fill) begin
      sum = 15'(level_r) + 15'($signed({1'b0, d.fillStep}));
    end else begin
      sum = 15'(level_r) - 15'($signed({1'b0, d.drainStep}));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_r <= dlc_pkg::LVL_EMPTY;
    end else if (d.sampleValid) begin
      if (sum > 15'(dlc_pkg::LVL_FULL)) begin
        level_r <= dlc_pkg::LVL_FULL;
      end else if (sum < 15'(dlc_pkg::LVL_EMPTY)) begin
        level_r <= dlc_pkg::LVL_EMPTY;
      end else begin
        level_r <= sum[dlc_pkg::LVL_W-1:0];
      end
    end
  end

  // Freeze wins over everything but reset so a switchover shows no phantom unlock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      locked_r <= 1'b0;
    end else if (d.freeze) begin
      locked_r <= locked_r;
    end else if (d.forceUnlock) begin
      locked_r <= 1'b0;
    end else if (level_r < dlc_pkg::LVL_LOW) begin
      locked_r <= 1'b0;
    end else if (level_r > dlc_pkg::LVL_HIGH) begin
      locked_r <= 1'b1;
    end
  end

  assign d.level  = level_r;
  assign d.locked = locked_r;

  property p_saturate;
    @(posedge clk_sys) disable iff (rst)
      (level_r <= dlc_pkg::LVL_FULL) && (level_r >= dlc_pkg::LVL_EMPTY);
  endproperty
  a_saturate: assert property (p_saturate) else $error("level out of range");

  property p_hold_level;
    @(posedge clk_sys) disable iff (rst) !d.sampleValid |=> $stable(level_r);
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("level moved without sample");

  property p_fill_rises;
    @(posedge clk_sys) disable iff (rst)
      d.sampleValid && fill && d.fillStep != 8'h00 && level_r < dlc_pkg::LVL_FULL |=> level_r > $past(level_r);
  endproperty
  a_fill_rises: assert property (p_fill_rises) else $error("fill did not raise level");

  property p_drain_falls;
    @(posedge clk_sys) disable iff (rst)
      d.sampleValid && !fill && d.drainStep != 8'h00 && level_r > dlc_pkg::LVL_EMPTY |=> level_r < $past(level_r);
  endproperty
  a_drain_falls: assert property (p_drain_falls) else $error("drain did not lower level");

  property p_lock;
    @(posedge clk_sys) disable iff (rst)
      !d.freeze && !d.forceUnlock && level_r > dlc_pkg::LVL_HIGH |=> locked_r;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not reported");

  property p_unlock;
    @(posedge clk_sys) disable iff (rst)
      !d.freeze && level_r < dlc_pkg::LVL_LOW |=> !locked_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not reported");

  property p_freeze;
    @(posedge clk_sys) disable iff (rst) d.freeze |=> $stable(locked_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("indication changed in switchover");
endmodule

// >>> design/dlc_loop_control.sv
// Lock detectors, tuning word clamp, history averaging and loop state control
`timescale 1ns/1ps
module dlc_loop_control #(
  parameter int HIST_LOG2 = 4
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          sampleValid,
  input  wire logic signed [23:0]            phaseErr,
  input  wire logic signed [24:0]            periodDiff,
  input  wire logic [dlc_pkg::PTHR_W-1:0]    phaseThresh,
  input  wire logic [dlc_pkg::FTHR_W-1:0]    freqThresh,
  input  wire logic [dlc_pkg::STEP_W-1:0]    phaseFill,
  input  wire logic [dlc_pkg::STEP_W-1:0]    phaseDrain,
  input  wire logic [dlc_pkg::STEP_W-1:0]    freqFill,
  input  wire logic [dlc_pkg::STEP_W-1:0]    freqDrain,
  input  wire logic [dlc_pkg::TW_W-1:0]      filterWord,
  input  wire logic [dlc_pkg::TW_W-1:0]      clampLow,
  input  wire logic [dlc_pkg::TW_W-1:0]      clampHigh,
  input  wire logic [dlc_pkg::TW_W-1:0]      freeRunWord,
  input  wire logic                          refValid,
  input  wire logic                          refSwitch,
  input  wire logic                          userHoldover,
  input  wire logic                          userFreeRun,
  output logic                               phaseLocked,
  output logic                               freqLocked,
  output logic [dlc_pkg::TW_W-1:0]           tuningWord,
  output logic                               loadProfile,
  output logic                               loopClosed,
  output logic                               inHoldover,
  output logic                               inFreeRun,
  output logic                               historyValid
);
  // Averaging needs two samples at least, and the sum must fit the accumulator
  if (HIST_LOG2 < 1 || HIST_LOG2 > dlc_pkg::HIST_LOG2_MAX) begin
    $error("HIST_LOG2 out of range");
  end

  localparam int ACC_W = dlc_pkg::TW_W + dlc_pkg::HIST_LOG2_MAX;

  dlc_pkg::dlc_state_t state_r;
  dlc_pkg::dlc_state_t state_nxt;
  logic [dlc_pkg::TW_W-1:0] clamped;
  logic [dlc_pkg::TW_W-1:0] tuning_r;
  logic [dlc_pkg::TW_W-1:0] avg_r;
  logic [ACC_W-1:0]         histAcc_r;
  logic [HIST_LOG2-1:0]     histCnt_r;
  logic                     histValid_r;
  logic [23:0]              phaseMag;
  logic [24:0]              periodMag;

  dlc_det_if #(.ERR_W(dlc_pkg::PTHR_W)) phIf ();
  dlc_det_if #(.ERR_W(dlc_pkg::FTHR_W)) frIf ();

  // Magnitudes saturate so a huge error never aliases under threshold
  assign phaseMag  = phaseErr[23] ? 24'(-phaseErr) : 24'(phaseErr);
  assign periodMag = periodDiff[24] ? 25'(-periodDiff) : 25'(periodDiff);

  assign phIf.sampleValid = sampleValid;
  assign phIf.errMag      = (phaseMag[23:16] != 8'h00) ? 16'hffff : phaseMag[15:0];
  assign phIf.threshold   = phaseThresh;
  assign phIf.fillStep    = phaseFill;
  assign phIf.drainStep   = phaseDrain;
  assign phIf.freeze      = (state_r == dlc_pkg::ST_SWITCH) || (state_r == dlc_pkg::ST_LOAD);
  assign phIf.forceUnlock = (state_r == dlc_pkg::ST_HOLDOVER) || (state_r == dlc_pkg::ST_FREERUN);

  assign frIf.sampleValid = sampleValid;
  assign frIf.errMag      = periodMag[24] ? 24'hffffff : periodMag[23:0];
  assign frIf.threshold   = freqThresh;
  assign frIf.fillStep    = freqFill;
  assign frIf.drainStep   = freqDrain;
  assign frIf.freeze      = phIf.freeze;
  assign frIf.forceUnlock = 1'b0;

  dlc_lock_detector uPhase (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (phIf)
  );

  dlc_lock_detector uFreq (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (frIf)
  );

  assign clamped = (filterWord < clampLow) ? clampLow :
                   (filterWord > clampHigh) ? clampHigh : filterWord;

  // Forced free run outranks forced holdover; a switch passes through load
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dlc_pkg::ST_FREERUN: begin
        if (!userFreeRun) begin
          state_nxt = userHoldover ? dlc_pkg::ST_HOLDOVER :
                      (refValid ? dlc_pkg::ST_LOAD : dlc_pkg::ST_HOLDOVER);
        end
      end
      dlc_pkg::ST_CLOSED: begin
        if (userFreeRun) begin
          state_nxt = dlc_pkg::ST_FREERUN;
        end else if (userHoldover || !refValid) begin
          state_nxt = dlc_pkg::ST_HOLDOVER;
        end else if (refSwitch) begin
          state_nxt = dlc_pkg::ST_SWITCH;
        end
      end
      dlc_pkg::ST_HOLDOVER: begin
        if (userFreeRun) begin
          state_nxt = dlc_pkg::ST_FREERUN;
        end else if (refValid && !userHoldover) begin
          state_nxt = dlc_pkg::ST_LOAD;
        end
      end
      dlc_pkg::ST_SWITCH: begin
        state_nxt = dlc_pkg::ST_LOAD;
      end
      dlc_pkg::ST_LOAD: begin
        state_nxt = dlc_pkg::ST_CLOSED;
      end
      default: begin
        state_nxt = dlc_pkg::ST_FREERUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= dlc_pkg::ST_FREERUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Holdover keeps the averaged word, or the last word when no history exists
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tuning_r <= '0;
    end else begin
      case (state_r)
        dlc_pkg::ST_CLOSED: tuning_r <= clamped;
        dlc_pkg::ST_FREERUN: tuning_r <= freeRunWord;
        default: tuning_r <= histValid_r ? avg_r : tuning_r;
      endcase
    end
  end

  // History: accumulate 2^HIST_LOG2 clamped samples while closed, then average
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      histAcc_r   <= '0;
      histCnt_r   <= '0;
      avg_r       <= '0;
      histValid_r <= 1'b0;
    end else if (state_r == dlc_pkg::ST_CLOSED && sampleValid) begin
      if (histCnt_r == {HIST_LOG2{1'b1}}) begin
        avg_r       <= TW_W_CUT(histAcc_r + ACC_W'(clamped));
        histValid_r <= 1'b1;
        histAcc_r   <= '0;
      end else begin
        histAcc_r <= histAcc_r + ACC_W'(clamped);
      end
      histCnt_r <= histCnt_r + 1'b1;
    end
  end

  function automatic logic [dlc_pkg::TW_W-1:0] TW_W_CUT(input logic [ACC_W-1:0] v);
    logic [ACC_W-1:0] s;
    s = v >> HIST_LOG2;
    return s[dlc_pkg::TW_W-1:0];
  endfunction

  assign phaseLocked  = phIf.locked;
  assign freqLocked   = frIf.locked;
  assign tuningWord   = tuning_r;
  assign loadProfile  = (state_r == dlc_pkg::ST_LOAD);
  assign loopClosed   = (state_r == dlc_pkg::ST_CLOSED);
  assign inHoldover   = (state_r == dlc_pkg::ST_HOLDOVER) || (state_r == dlc_pkg::ST_SWITCH);
  assign inFreeRun    = (state_r == dlc_pkg::ST_FREERUN);
  assign historyValid = histValid_r;

  sequence s_switch_in;
    state_r == dlc_pkg::ST_CLOSED && !userFreeRun && !userHoldover && refValid && refSwitch;
  endsequence
  sequence s_switch_out;
    state_r == dlc_pkg::ST_SWITCH ##1 state_r == dlc_pkg::ST_LOAD ##1 state_r == dlc_pkg::ST_CLOSED;
  endsequence
  property p_switch;
    @(posedge clk_sys) disable iff (rst) s_switch_in |=> s_switch_out;
  endproperty
  a_switch: assert property (p_switch) else $error("switchover sequence wrong");

  property p_forced_hold;
    @(posedge clk_sys) disable iff (rst)
      state_r == dlc_pkg::ST_HOLDOVER && userHoldover && !userFreeRun |=> state_r == dlc_pkg::ST_HOLDOVER;
  endproperty
  a_forced_hold: assert property (p_forced_hold) else $error("left holdover while forced");

  property p_recover;
    @(posedge clk_sys) disable iff (rst)
      state_r == dlc_pkg::ST_HOLDOVER && refValid && !userHoldover && !userFreeRun
      |=> loadProfile ##1 loopClosed;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery from holdover");

  property p_hold_const;
    @(posedge clk_sys) disable iff (rst)
      state_r == dlc_pkg::ST_HOLDOVER && $past(state_r) == dlc_pkg::ST_HOLDOVER |=> $stable(tuning_r) || $changed(avg_r);
  endproperty
  a_hold_const: assert property (p_hold_const) else $error("holdover word moved");

  property p_clamp;
    @(posedge clk_sys) disable iff (rst)
      loopClosed && clampLow <= clampHigh |=> tuning_r >= $past(clampLow) && tuning_r <= $past(clampHigh);
  endproperty
  a_clamp: assert property (p_clamp) else $error("tuning word outside clamp");

  property p_ho_unlock;
    @(posedge clk_sys) disable iff (rst) inHoldover && !phIf.freeze |=> !phaseLocked;
  endproperty
  a_ho_unlock: assert property (p_ho_unlock) else $error("phase lock shown in holdover");

  property p_force_fr;
    @(posedge clk_sys) disable iff (rst) userFreeRun && (loopClosed || state_r == dlc_pkg::ST_HOLDOVER) |=> inFreeRun;
  endproperty
  a_force_fr: assert property (p_force_fr) else $error("forced free run ignored");

  property p_freerun_word;
    @(posedge clk_sys) disable iff (rst) inFreeRun |=> tuning_r == $past(freeRunWord);
  endproperty
  a_freerun_word: assert property (p_freerun_word) else $error("free run word not applied");

  property p_load_once;
    @(posedge clk_sys) disable iff (rst) loadProfile |=> !loadProfile;
  endproperty
  a_load_once: assert property (p_load_once) else $error("profile load held too long");

  property p_hist_sticky;
    @(posedge clk_sys) disable iff (rst) historyValid |=> historyValid;
  endproperty
  a_hist_sticky: assert property (p_hist_sticky) else $error("history average lost");

  property p_switch_frozen;
    @(posedge clk_sys) disable iff (rst) phIf.freeze |=> $stable(phaseLocked) && $stable(freqLocked);
  endproperty
  a_switch_frozen: assert property (p_switch_frozen) else $error("lock changed during switchover");
endmodule

// >>> shared/dlc_det_if.sv
// Interface joining the loop controller to one lock detector
`timescale 1ns/1ps
interface dlc_det_if #(parameter int ERR_W = 16);
  logic                         sampleValid;
  logic [ERR_W-1:0]             errMag;
  logic [ERR_W-1:0]             threshold;
  logic [dlc_pkg::STEP_W-1:0]   fillStep;
  logic [dlc_pkg::STEP_W-1:0]   drainStep;
  logic                         freeze;
  logic                         forceUnlock;
  logic                         locked;
  logic signed [dlc_pkg::LVL_W-1:0] level;
  modport ctrl (output sampleValid, errMag, threshold, fillStep, drainStep, freeze, forceUnlock,
                input locked, level);
  modport det  (input sampleValid, errMag, threshold, fillStep, drainStep, freeze, forceUnlock,
                output locked, level);
endinterface

// >>> shared/dlc_pkg.sv
// Constants and types for the lock detector and loop control block
// Operation
// - Level accumulator saturates between -2048 and +2048
// - Level below -1024 reports unlocked
// - Level above +1024 reports locked
// - Between marks, indication holds previous value
// - Fill and drain steps are 8-bit settings
// - Each sample: exactly one fill or drain
// - Phase threshold is 16-bit picoseconds
// - Magnitude within threshold fills, else drains
// - Free run or holdover forces phase unlock
// - Switchover preserves both detector states
// - Frequency detector uses absolute period difference
// - Frequency threshold is 24-bit picoseconds
// - Tuning word clamped to programmed range; only the closed loop word is clamped, free run outputs freeRunWord unclamped
// - Averaged tuning word history drives holdover
// - Switchover: brief holdover, load, reclose loop
// - Holdover keeps output frequency constant
// - Valid reference ends holdover, recovers loop
// - Forced holdover bit blocks automatic exit
// - Forced holdover and free run bits
package dlc_pkg;
  localparam int LVL_W = 13;
  localparam logic signed [LVL_W-1:0] LVL_EMPTY = -13'sd2048;
  localparam logic signed [LVL_W-1:0] LVL_FULL  = 13'sd2048;
  localparam logic signed [LVL_W-1:0] LVL_LOW   = -13'sd1024;
  localparam logic signed [LVL_W-1:0] LVL_HIGH  = 13'sd1024;
  localparam int STEP_W  = 8;
  localparam int PTHR_W  = 16;
  localparam int FTHR_W  = 24;
  localparam int TW_W    = 32;
  localparam int HIST_LOG2_MAX = 8;
  typedef enum logic [2:0] {
    ST_FREERUN,
    ST_CLOSED,
    ST_HOLDOVER,
    ST_SWITCH,
    ST_LOAD
  } dlc_state_t;
endpackage

// >>> verification/dlc_far_side.sv
// Far side model: phase error and period difference sample streams around the thresholds
`timescale 1ns/1ps
module dlc_far_side (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [7:0]         goodPct,
  input  wire logic [15:0]        phaseThresh,
  input  wire logic [23:0]        freqThresh,
  output logic                    sampleValid,
  output logic signed [23:0]      phaseErr,
  output logic signed [24:0]      periodDiff
);
  // Boundary values come often, since off-by-one faults hide there
  function automatic int pick(int thr, bit good);
    int m;
    m = good ? (($urandom % 4 == 0) ? thr : $urandom % (thr + 1)) :
               (($urandom % 4 == 0) ? thr + 1 : thr + 1 + $urandom % 70000);
    return $urandom % 2 ? -m : m;
  endfunction
  initial begin
    sampleValid = 1'b0;
    phaseErr = '0;
    periodDiff = '0;
  end
  // Data changes every cycle, valid or not, so stale values never pass
  always @(posedge clk_sys) begin
    sampleValid <= !rst && ($urandom % 4 != 0);
    phaseErr <= 24'(pick(int'(phaseThresh), ($urandom % 100) < goodPct));
    periodDiff <= 25'(pick(int'(freqThresh), ($urandom % 100) < goodPct));
  end
endmodule

// >>> verification/dlc_loop_control_tb.sv
// Testbench for the lock detector and loop control block
`timescale 1ns/1ps
module dlc_loop_control_tb;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 sampleValid;
  logic signed [23:0]   phaseErr;
  logic signed [24:0]   periodDiff;
  logic [15:0]          phaseThresh = 16'h0064;
  logic [23:0]          freqThresh = 24'h0000c8;
  logic [7:0]           phaseFill = 8'h10, phaseDrain = 8'h10, freqFill = 8'h10, freqDrain = 8'h10;
  logic [7:0]           goodPct = 8'h64;
  logic [31:0]          filterWord = 32'h00001000, clampLow = 32'h00000800, clampHigh = 32'h00002000;
  logic [31:0]          freeRunWord = 32'h00001234, tuningWord;
  logic                 refValid = 1'b0, refSwitch = 1'b0, userHoldover = 1'b0, userFreeRun = 1'b1;
  logic                 phaseLocked, freqLocked, loadProfile, loopClosed, inHoldover, inFreeRun, historyValid;
  logic [31:0]          fwTab [3] = '{32'h00000010, 32'hffff0000, 32'h00001800};
  int                   fails = 0, samples_checked = 0, cycles = 0, pl, fl;
  bit                   pk, fk;
  dlc_pkg::dlc_state_t  ms;
  localparam int        HLOG = 1;
  logic [31:0]          hq [$];
  logic [31:0]          tw, avg;
  longint               hs;
  bit                   hv;

  dlc_far_side dlc_far_side_i (.clk_sys(clk_sys), .rst(rst), .goodPct(goodPct), .phaseThresh(phaseThresh),
    .freqThresh(freqThresh), .sampleValid(sampleValid), .phaseErr(phaseErr), .periodDiff(periodDiff));
  dlc_loop_control #(.HIST_LOG2(HLOG)) dlc_loop_control_i (.clk_sys(clk_sys), .rst(rst),
    .sampleValid(sampleValid), .phaseErr(phaseErr), .periodDiff(periodDiff), .phaseThresh(phaseThresh),
    .freqThresh(freqThresh), .phaseFill(phaseFill), .phaseDrain(phaseDrain), .freqFill(freqFill),
    .freqDrain(freqDrain), .filterWord(filterWord), .clampLow(clampLow), .clampHigh(clampHigh),
    .freeRunWord(freeRunWord), .refValid(refValid), .refSwitch(refSwitch), .userHoldover(userHoldover),
    .userFreeRun(userFreeRun), .phaseLocked(phaseLocked), .freqLocked(freqLocked), .tuningWord(tuningWord),
    .loadProfile(loadProfile), .loopClosed(loopClosed), .inHoldover(inHoldover), .inFreeRun(inFreeRun),
    .historyValid(historyValid));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chkBit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0b seen %0b", n, e, g);
    end
  endtask
  task automatic chkWord(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic int step(int lv, bit fill, int f, int d);
    lv = fill ? lv + f : lv - d;
    return lv > 2048 ? 2048 : (lv < -2048 ? -2048 : lv);
  endfunction
  function automatic int mag(int v);
    return v < 0 ? -v : v;
  endfunction
  function automatic logic [31:0] clampOf(logic [31:0] w);
    return w < clampLow ? clampLow : (w > clampHigh ? clampHigh : w);
  endfunction
  // Switch and load run to completion; forcing acts once the loop is settled
  function automatic dlc_pkg::dlc_state_t nxt(dlc_pkg::dlc_state_t s);
    if (s == dlc_pkg::ST_SWITCH) return dlc_pkg::ST_LOAD;
    if (s == dlc_pkg::ST_LOAD) return dlc_pkg::ST_CLOSED;
    if (userFreeRun) return dlc_pkg::ST_FREERUN;
    if (userHoldover) return dlc_pkg::ST_HOLDOVER;
    case (s)
      dlc_pkg::ST_CLOSED: return !refValid ? dlc_pkg::ST_HOLDOVER : (refSwitch ? dlc_pkg::ST_SWITCH : s);
      default:            return refValid ? dlc_pkg::ST_LOAD : dlc_pkg::ST_HOLDOVER;
    endcase
  endfunction

  // Reference model; lock looks at the level held before this edge
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      summarize();
    end else if (rst) begin
      pl = -2048;
      fl = -2048;
      pk = 0;
      fk = 0;
      ms = dlc_pkg::ST_FREERUN;
      tw = '0;
      avg = '0;
      hv = 0;
      hq.delete();
    end else begin
      if (ms != dlc_pkg::ST_SWITCH && ms != dlc_pkg::ST_LOAD) begin
        if (ms != dlc_pkg::ST_CLOSED) pk = 0;
        else if (pl > 1024) pk = 1;
        else if (pl < -1024) pk = 0;
        if (fl > 1024) fk = 1;
        else if (fl < -1024) fk = 0;
      end
      if (sampleValid === 1'b1) begin
        pl = step(pl, mag(phaseErr) <= phaseThresh, phaseFill, phaseDrain);
        fl = step(fl, mag(periodDiff) <= freqThresh, freqFill, freqDrain);
      end
      // Word follows the state and history held before this edge
      if (ms == dlc_pkg::ST_CLOSED) tw = clampOf(filterWord);
      else if (ms == dlc_pkg::ST_FREERUN) tw = freeRunWord;
      else if (hv) tw = avg;
      if (ms == dlc_pkg::ST_CLOSED && sampleValid === 1'b1) begin
        hq.push_back(clampOf(filterWord));
        if (hq.size() == (1 << HLOG)) begin
          hs = 0;
          foreach (hq[j]) hs += hq[j];
          avg = 32'(hs >> HLOG);
          hv = 1;
          hq.delete();
        end
      end
      ms = nxt(ms);
    end
  end

  always @(negedge clk_sys) begin
    if (cycles > 0) begin
      chkBit("phaseLocked", pk, phaseLocked);
      chkBit("freqLocked", fk, freqLocked);
      chkBit("inFreeRun", ms == dlc_pkg::ST_FREERUN, inFreeRun);
      chkBit("inHoldover", ms inside {dlc_pkg::ST_HOLDOVER, dlc_pkg::ST_SWITCH}, inHoldover);
      chkBit("loadProfile", ms == dlc_pkg::ST_LOAD, loadProfile);
      chkBit("loopClosed", ms == dlc_pkg::ST_CLOSED, loopClosed);
      chkWord("tuningWord", tw, tuningWord);
      chkBit("historyValid", hv, historyValid);
    end
  end

  initial begin
    void'($urandom(89));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(20);
    chkWord("tuningWord", freeRunWord, tuningWord);
    @(posedge clk_sys) {userFreeRun, refValid} <= 2'b01;
    foreach (fwTab[i]) begin
      @(posedge clk_sys) filterWord <= fwTab[i];
      cyc(20);
      chkWord("tuningWord", clampOf(fwTab[i]), tuningWord);
    end
    chkBit("historyValid", 1'b1, historyValid);
    // Saturating fill first, then random mixes and a zero threshold
    for (int k = 0; k < 12; k++) begin
      @(posedge clk_sys);
      goodPct <= (k % 3 == 0) ? 8'h64 : 8'($urandom % 101);
      phaseFill <= k == 0 ? 8'hff : 8'($urandom);
      phaseDrain <= k == 1 ? 8'h10 : 8'($urandom);
      freqFill <= 8'($urandom);
      freqDrain <= 8'($urandom);
      phaseThresh <= k == 2 ? 16'h0000 : 16'($urandom % 2000);
      freqThresh <= k == 3 ? 24'h000000 : 24'($urandom % 5000);
      cyc(300);
    end
    @(posedge clk_sys) {goodPct, phaseFill, freqFill} <= {8'h64, 8'h40, 8'h40};
    cyc(100);
    @(posedge clk_sys) {refSwitch, goodPct} <= {1'b1, 8'h00};
    @(posedge clk_sys) refSwitch <= 1'b0;
    cyc(20);
    @(posedge clk_sys) {goodPct, filterWord} <= {8'h64, 32'h00001500};
    cyc(60);
    @(posedge clk_sys) userHoldover <= 1'b1;
    cyc(3);
    @(posedge clk_sys) {filterWord, refValid} <= {32'h00001f00, 1'b0};
    cyc(10);
    @(posedge clk_sys) refValid <= 1'b1;
    cyc(20);
    chkWord("tuningWord", 32'h00001500, tuningWord);
    @(posedge clk_sys) userHoldover <= 1'b0;
    cyc(40);
    chkWord("tuningWord", 32'h00001f00, tuningWord);
    @(posedge clk_sys) refValid <= 1'b0;
    cyc(20);
    @(posedge clk_sys) {refValid, userFreeRun} <= 2'b11;
    cyc(10);
    chkWord("tuningWord", freeRunWord, tuningWord);
    @(posedge clk_sys) userFreeRun <= 1'b0;
    cyc(40);
    // Second reset in mid-run, with the loop closed and locked
    @(posedge clk_sys) rst <= 1'b1;
    cyc(3);
    chkWord("tuningWord", 32'h00000000, tuningWord);
    chkBit("historyValid", 1'b0, historyValid);
    @(posedge clk_sys) rst <= 1'b0;
    cyc(40);
    // Forced free run from closed, forced holdover from free run, then no reference
    @(posedge clk_sys) userFreeRun <= 1'b1;
    cyc(5);
    @(posedge clk_sys) {userFreeRun, userHoldover} <= 2'b01;
    cyc(5);
    @(posedge clk_sys) {userFreeRun, userHoldover, refValid} <= 3'b100;
    cyc(5);
    @(posedge clk_sys) userFreeRun <= 1'b0;
    cyc(5);
    @(posedge clk_sys) refValid <= 1'b1;
    cyc(10);
    summarize();
  end
endmodule
